// ---- tcs_pkg.sv ----
// Shared constants for the tag command state controller
`default_nettype none
package tcs_pkg;
  // Major states, one-hot
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_ARBITRATION = 3'b010,
    ST_EXCHANGE = 3'b100
  } tcs_state_t;

  // Comparison variants carried beside a group command
  localparam logic [1:0] CMP_EQUAL = 2'h0;
  localparam logic [1:0] CMP_NOT_EQUAL = 2'h1;
  localparam logic [1:0] CMP_GREATER = 2'h2;
  localparam logic [1:0] CMP_LESS = 2'h3;

  // Decoded command codes
  localparam logic [7:0] CMD_PICK_MEM = 8'h01;
  localparam logic [7:0] CMD_DROP_MEM = 8'h02;
  localparam logic [7:0] CMD_PICK_FLAG = 8'h03;
  localparam logic [7:0] CMD_DROP_FLAG = 8'h04;
  localparam logic [7:0] CMD_MULTI_DROP = 8'h05;
  localparam logic [7:0] CMD_FAIL = 8'h06;
  localparam logic [7:0] CMD_SUCCESS = 8'h07;
  localparam logic [7:0] CMD_RESEND = 8'h08;
  localparam logic [7:0] CMD_INIT = 8'h09;
  localparam logic [7:0] CMD_READ = 8'h0a;
  localparam logic [7:0] CMD_ARB_READ = 8'h0b;
  localparam logic [7:0] CMD_VERIFIED_QUAD_READ = 8'h0c;
  localparam logic [7:0] CMD_WRITE = 8'h0d;
  localparam logic [7:0] CMD_BCAST_WRITE = 8'h0e;
  localparam logic [7:0] CMD_BCAST_QUAD_WRITE = 8'h0f;
  localparam logic [7:0] CMD_QUAD_WRITE = 8'h10;
  localparam logic [7:0] CMD_LOCK = 8'h11;
  localparam logic [7:0] CMD_LOCK_QUERY = 8'h12;
  localparam logic [7:0] CMD_PORT_READ = 8'h13;
  localparam logic [7:0] CMD_VAR_READ = 8'h14;

  // Flag byte layout
  localparam int FLAG_EXCHANGE_BIT = 0;
  localparam int FLAG_WRITE_OK_BIT = 1;

  // Register map, byte addresses
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_FLAG_LSB = 8;
  localparam int COUNT_IGNORED_LSB = 8;
  localparam int CNT_W = 8;

  // Write-success lapses at the second command after a write
  localparam logic [1:0] WOK_LAPSE_AT = 2'h1;
endpackage : tcs_pkg
`default_nettype wire

// ---- tcs_compare.sv ----
// Masked byte comparison with selectable relation
`timescale 1ns/1ps
`default_nettype none
module tcs_compare (
  input wire logic [7:0] tagByte,
  input wire logic [7:0] refByte,
  input wire logic [7:0] mask,
  input wire logic [1:0] cmp,
  output logic match
);
  import tcs_pkg::*;
  wire logic [7:0] tagMasked = tagByte & mask;
  wire logic [7:0] refMasked = refByte & mask;
  wire logic isEq = (tagMasked == refMasked);
  wire logic isGt = (tagMasked > refMasked);
  wire logic isLt = (tagMasked < refMasked);
  assign match = (cmp == CMP_EQUAL) ? isEq :
                 (cmp == CMP_NOT_EQUAL) ? !isEq :
                 (cmp == CMP_GREATER) ? isGt : isLt;
endmodule : tcs_compare
`default_nettype wire

// ---- tcs_sat_counter.sv ----
// Saturating event counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module tcs_sat_counter #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic inc,
  output logic [W-1:0] count
);
  wire logic atTop = &count;
  wire logic [W-1:0] next_count = clear ? '0 : (inc && !atTop) ? count + 1'b1 : count;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) count <= '0;
    else count <= next_count;
  end
endmodule : tcs_sat_counter
`default_nettype wire

// ---- tcs_state_ctrl.sv ----
// Command acceptance and major-state controller of the tag
`timescale 1ns/1ps
`default_nettype none
module tcs_state_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  // Decoded forward-link command
  input wire logic cmdValid,
  input wire logic cmdCrcOk,
  input wire logic [7:0] cmdCode,
  input wire logic [1:0] cmdCmp,
  input wire logic [7:0] cmdMask,
  input wire logic [7:0] cmdData,
  input wire logic [63:0] cmdUid,
  // Tag-side context
  input wire logic [63:0] tagUid,
  input wire logic [7:0] memData,
  input wire logic progDone,
  input wire logic progFail,
  // Action towards memory and response logic
  output logic actValid,
  output logic [7:0] actCode,
  output tcs_pkg::tcs_state_t tagState,
  output logic [7:0] flagByte,
  // Register port
  input wire logic [tcs_pkg::REG_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  import tcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command classes
  tcs_state_t stateReg;
  logic exchangeFlag;
  logic writeOk;
  logic ctrlEnable;
  logic [7:0] lastWritten;
  logic [1:0] cmdsAfterWrite;

  wire logic isPickMem = (cmdCode == CMD_PICK_MEM);
  wire logic isDropMem = (cmdCode == CMD_DROP_MEM);
  wire logic isPickFlag = (cmdCode == CMD_PICK_FLAG);
  wire logic isDropFlag = (cmdCode == CMD_DROP_FLAG);
  wire logic isMultiDrop = (cmdCode == CMD_MULTI_DROP);
  wire logic isAnti = (cmdCode == CMD_FAIL) || (cmdCode == CMD_SUCCESS) ||
                      (cmdCode == CMD_RESEND);
  wire logic isInit = (cmdCode == CMD_INIT);
  wire logic isArbRead = (cmdCode == CMD_ARB_READ);
  wire logic isVerRead = (cmdCode == CMD_VERIFIED_QUAD_READ);
  wire logic isLock = (cmdCode == CMD_LOCK);
  wire logic isSingleWr = (cmdCode == CMD_WRITE);
  wire logic isQuadWr = (cmdCode == CMD_QUAD_WRITE);
  wire logic isBcast = (cmdCode == CMD_BCAST_WRITE) || (cmdCode == CMD_BCAST_QUAD_WRITE);
  // Addressed commands valid in every state
  wire logic isAddr = (cmdCode == CMD_READ) || isSingleWr || isQuadWr ||
                      (cmdCode == CMD_LOCK_QUERY) || (cmdCode == CMD_PORT_READ) ||
                      (cmdCode == CMD_VAR_READ);
  wire logic isPick = isPickMem || isPickFlag;
  wire logic isDrop = isDropMem || isDropFlag;
  // Flag variants only know equal and not equal
  wire logic flagCmpBad = (isPickFlag || isDropFlag) && cmdCmp[1];
  wire logic isKnown = (isPick || isDrop || isMultiDrop || isAnti || isInit || isArbRead ||
                        isVerRead || isLock || isBcast || isAddr) && !flagCmpBad;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance per state
  wire logic stReady = (stateReg == ST_READY);
  wire logic stArb = (stateReg == ST_ARBITRATION);
  wire logic stExch = (stateReg == ST_EXCHANGE);
  // A damaged or unknown frame never reaches the state logic
  wire logic cmdOk = cmdValid && cmdCrcOk && isKnown && ctrlEnable;
  wire logic activeReady = isPick || isInit || isAddr || isVerRead;
  wire logic activeArb = isPick || isDrop || isMultiDrop || isAnti || isInit || isAddr ||
                         isArbRead || isVerRead || isBcast;
  wire logic activeExch = isInit || isAddr || isArbRead || isVerRead || isBcast || isLock;
  wire logic accept = cmdOk && ((stReady && activeReady) || (stArb && activeArb) ||
                                (stExch && activeExch));

  ////////////////////////////////////////////////////////////////////////////
  // Match conditions
  wire logic memMatch;
  wire logic flagMatch;
  tcs_compare uMemCmp (
    .tagByte(memData),
    .refByte(cmdData),
    .mask(cmdMask),
    .cmp(cmdCmp),
    .match(memMatch)
  );
  tcs_compare uFlagCmp (
    .tagByte(flagByte),
    .refByte(cmdData),
    .mask(cmdMask),
    .cmp(cmdCmp),
    .match(flagMatch)
  );
  wire logic uidMatch = (cmdUid == tagUid);
  wire logic groupMatch = (isPickMem || isDropMem) ? memMatch : flagMatch;
  wire logic multiMatch = (cmdData == lastWritten) && writeOk;
  wire logic verMatch = uidMatch && writeOk;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  tcs_state_t next_stateReg;
  always_comb begin
    next_stateReg = stateReg;
    if (accept) begin
      if (isInit) begin
        next_stateReg = ST_READY;
      end else begin
        case (stateReg)
          ST_READY: begin
            if (isPick && groupMatch) next_stateReg = ST_ARBITRATION;
            else if (isAddr && uidMatch) next_stateReg = ST_EXCHANGE;
            else if (isVerRead && verMatch) next_stateReg = ST_EXCHANGE;
          end
          ST_ARBITRATION: begin
            // Picks, anticollision and broadcast writes keep arbitration
            if (isDrop && groupMatch) next_stateReg = ST_READY;
            else if (isMultiDrop && multiMatch) next_stateReg = ST_READY;
            else if ((isAddr || isArbRead) && uidMatch) next_stateReg = ST_EXCHANGE;
            else if (isVerRead && verMatch) next_stateReg = ST_EXCHANGE;
          end
          ST_EXCHANGE: next_stateReg = ST_EXCHANGE;
          default: next_stateReg = ST_READY;
        endcase
      end
    end
  end

  // Which accepted commands carry work to the neighbours
  wire logic addrHit = (isAddr || isArbRead || isLock) && uidMatch;
  wire logic verHit = isVerRead && uidMatch && (stExch || writeOk);
  wire logic bcastHit = isBcast && !stReady;
  wire logic antiHit = isAnti && stArb;
  wire logic doAct = accept && (isInit || addrHit || verHit || bcastHit || antiHit);
  wire logic doWrite = doAct && (isSingleWr || isQuadWr || isBcast);
  wire logic enterExch = (next_stateReg == ST_EXCHANGE) && !stExch;

  ////////////////////////////////////////////////////////////////////////////
  // State and flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) stateReg <= ST_READY;
    else stateReg <= next_stateReg;
  end

  // Initialize and entry cannot meet: entry needs a non-initialize command
  wire logic next_exchangeFlag = enterExch ? 1'b1 :
                                 (accept && isInit) ? 1'b0 : exchangeFlag;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) exchangeFlag <= 1'b0;
    else exchangeFlag <= next_exchangeFlag;
  end

  // Window of commands after a write; lapse clears write-ok
  wire logic wokLapse = cmdValid && (cmdsAfterWrite == WOK_LAPSE_AT) && !doWrite;
  wire logic [1:0] next_cmdsAfterWrite = doWrite ? 2'h0 :
                                         (cmdValid && cmdsAfterWrite != 2'h3) ?
                                         cmdsAfterWrite + 2'h1 : cmdsAfterWrite;
  // A completed programming cycle wins over any clear
  wire logic next_writeOk = progDone ? 1'b1 :
                            (progFail || wokLapse) ? 1'b0 : writeOk;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      writeOk <= 1'b0;
      cmdsAfterWrite <= 2'h3;
    end else begin
      writeOk <= next_writeOk;
      cmdsAfterWrite <= next_cmdsAfterWrite;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) lastWritten <= 8'h00;
    else if (doWrite) lastWritten <= cmdData;
  end

  always_comb begin
    flagByte = 8'h00;
    flagByte[FLAG_EXCHANGE_BIT] = exchangeFlag;
    flagByte[FLAG_WRITE_OK_BIT] = writeOk;
  end
  assign tagState = stateReg;

  // Action strobe towards memory, lock and response logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      actValid <= 1'b0;
      actCode <= 8'h00;
    end else begin
      actValid <= doAct;
      actCode <= doAct ? cmdCode : actCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  wire logic selCtrl = (regAddr == REG_CTRL);
  wire logic selStatus = (regAddr == REG_STATUS);
  wire logic selCount = (regAddr == REG_COUNT);
  wire logic ctrlWr = regWr && selCtrl;
  wire logic cntClear = ctrlWr && regWdata[CTRL_CLEAR_BIT];
  wire logic [CNT_W-1:0] acceptCount;
  wire logic [CNT_W-1:0] ignoreCount;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) ctrlEnable <= CTRL_ENABLE_RESET;
    else if (ctrlWr) ctrlEnable <= regWdata[CTRL_ENABLE_BIT];
  end

  tcs_sat_counter #(.W(CNT_W)) uAcceptCnt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clear(cntClear),
    .inc(accept),
    .count(acceptCount)
  );
  tcs_sat_counter #(.W(CNT_W)) uIgnoreCnt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clear(cntClear),
    .inc(cmdValid && !accept),
    .count(ignoreCount)
  );

  wire logic [31:0] ctrlView = {31'h0, ctrlEnable};
  wire logic [31:0] statusView = {16'h0, flagByte, 5'h0, stateReg};
  wire logic [31:0] countView = {16'h0, ignoreCount, acceptCount};
  wire logic [31:0] readMux = selCtrl ? ctrlView : selStatus ? statusView :
                              selCount ? countView : 32'h0;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) regRdata <= 32'h0;
    else regRdata <= regRd ? readMux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence seqInitTaken;
    accept && isInit;
  endsequence
  sequence seqReadyClean;
    stReady && !exchangeFlag && actValid && (actCode == CMD_INIT);
  endsequence
  sequence seqAddrEntry;
    accept && isAddr && uidMatch && !stExch;
  endsequence

  AST_IGNORED_NO_MOVE: assert property (
    cmdValid && !accept |=> $stable(stateReg) && !actValid)
    else $error("ignored command changed state");
  AST_CRC_BAD_DROPPED: assert property (
    cmdValid && !cmdCrcOk |=> $stable(stateReg) && $stable(exchangeFlag))
    else $error("damaged command acted upon");
  AST_FLAG_CMP_LIMIT: assert property (
    cmdValid && (isPickFlag || isDropFlag) && cmdCmp[1] |=> $stable(stateReg))
    else $error("flag command with ordered compare accepted");
  AST_PICK_TO_ARB: assert property (
    accept && isPick && stReady && groupMatch |=> stArb && $stable(exchangeFlag))
    else $error("matching pick did not enter arbitration");
  AST_DROP_ONLY_ARB: assert property (
    cmdOk && isDrop && !stArb |=> $stable(stateReg))
    else $error("drop acted outside arbitration");
  AST_MULTI_DROP: assert property (
    accept && isMultiDrop |=> (stReady == $past(multiMatch)))
    else $error("multi-drop outcome wrong");
  AST_ANTI_STAYS: assert property (
    cmdOk && isAnti |=> $stable(stateReg))
    else $error("anticollision command moved state");
  AST_INIT_READY: assert property (
    seqInitTaken |=> seqReadyClean)
    else $error("initialize left tag outside ready or flag set");
  AST_ADDR_ENTRY: assert property (
    seqAddrEntry |=> stExch && exchangeFlag && actValid)
    else $error("addressed match did not enter exchange");
  AST_VERIFY_NEEDS_WOK: assert property (
    accept && isVerRead && !writeOk && !stExch |=> $stable(stateReg) && !actValid)
    else $error("verified read entered exchange without write-ok");
  AST_EXCH_FLAG_HELD: assert property (
    stExch |-> exchangeFlag)
    else $error("exchange flag clear while in exchange");
  AST_LOCK_ONLY_EXCH: assert property (
    cmdOk && isLock && !stExch |=> !actValid && $stable(stateReg))
    else $error("lock acted outside exchange");
  AST_BCAST_STAYS: assert property (
    accept && isBcast && stArb |=> stArb && actValid)
    else $error("broadcast write left arbitration");
  AST_WOK_CLEAR: assert property (
    progFail && !progDone |=> !flagByte[FLAG_WRITE_OK_BIT])
    else $error("write-ok survived failed programming");
  AST_FLAG_PICK: assert property (
    accept && isPickFlag && stReady |=> (stArb == $past(flagMatch)))
    else $error("flag pick outcome wrong");
  AST_DROP_MATCH: assert property (
    accept && isDrop |=> (stReady == $past(groupMatch)))
    else $error("drop outcome wrong");
  AST_ANTI_ACT: assert property (
    accept && isAnti |=> stArb && actValid)
    else $error("anticollision command not executed in arbitration");
  AST_ARB_READ_ENTRY: assert property (
    accept && isArbRead && stArb |=> (stExch == $past(uidMatch)))
    else $error("arbitration read outcome wrong");
  AST_EXCH_STAYS: assert property (
    stExch && !(accept && isInit) |=> stExch)
    else $error("exchange left without initialize");
  AST_RESET_READY: assert property (
    $rose(arst_n) |-> stReady && !exchangeFlag)
    else $error("tag not in ready after reset");
endmodule : tcs_state_ctrl
`default_nettype wire

// ---- tcs_reader_model.sv ----
// Interrogator model: issues decoded commands towards the tag controller
`timescale 1ns/1ps
`default_nettype none
module tcs_reader_model (
  input wire logic core_clk,
  output logic cmdValid,
  output logic cmdCrcOk,
  output logic [7:0] cmdCode,
  output logic [1:0] cmdCmp,
  output logic [7:0] cmdMask,
  output logic [7:0] cmdData,
  output logic [63:0] cmdUid
);
  initial begin
    cmdValid = 1'b0;
    cmdCrcOk = 1'b0;
    cmdCode = 8'h00;
    cmdCmp = 2'h0;
    cmdMask = 8'h00;
    cmdData = 8'h00;
    cmdUid = 64'h0;
  end

  ////////////////////////////////////////////////////////////////
  // One command, one cycle; the caller picks the compare variant
  task automatic send(input logic [7:0] code, input logic [1:0] cmp, input logic [7:0] data,
      input logic [63:0] uid, input logic crc);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdCrcOk <= crc;
    cmdCode <= code;
    cmdCmp <= cmp;
    cmdMask <= 8'hff;
    cmdData <= data;
    cmdUid <= uid;
    @(posedge core_clk);
    // Released fields go inverted, the mask to zero, so stale values never look valid
    cmdValid <= 1'b0;
    cmdCrcOk <= ~crc;
    cmdCode <= ~code;
    cmdCmp <= ~cmp;
    cmdMask <= 8'h00;
    cmdData <= ~data;
    cmdUid <= ~uid;
  endtask : send
endmodule : tcs_reader_model
`default_nettype wire

// ---- tb_tcs_state_ctrl.sv ----
// Self-checking bench for the tag command state controller
`timescale 1ns/1ps
`default_nettype none
module tb_tcs_state_ctrl;
  import tcs_pkg::*;
  localparam logic [63:0] OWN_UID = 64'h0123_4567_89ab_cdef;
  localparam logic [2:0] RDY = 3'b001;
  localparam logic [2:0] ARB = 3'b010;
  localparam logic [2:0] EXC = 3'b100;
  localparam logic [7:0] HIT_D [4] = '{8'h50, 8'h51, 8'h4f, 8'h51};
  localparam logic [7:0] MISS_D [4] = '{8'h51, 8'h50, 8'h50, 8'h50};
  localparam logic [7:0] ADDR_CMDS [6] = '{CMD_READ, CMD_WRITE, CMD_QUAD_WRITE,
    CMD_LOCK_QUERY, CMD_PORT_READ, CMD_VAR_READ};
  localparam logic [7:0] EXC_CMDS [11] = '{CMD_READ, CMD_ARB_READ, CMD_VERIFIED_QUAD_READ,
    CMD_WRITE, CMD_BCAST_WRITE, CMD_BCAST_QUAD_WRITE, CMD_QUAD_WRITE, CMD_LOCK,
    CMD_LOCK_QUERY, CMD_PORT_READ, CMD_VAR_READ};
  localparam logic [7:0] RDY_OFF [10] = '{CMD_DROP_MEM, CMD_DROP_FLAG, CMD_MULTI_DROP,
    CMD_FAIL, CMD_SUCCESS, CMD_RESEND, CMD_LOCK, CMD_ARB_READ, CMD_BCAST_WRITE,
    CMD_BCAST_QUAD_WRITE};
  logic core_clk = 1'b0;
  logic arst_n = 1'b1;
  logic [7:0] memData = 8'h50;
  logic progDone = 1'b0;
  logic progFail = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic cmdValid;
  logic cmdCrcOk;
  logic [7:0] cmdCode;
  logic [1:0] cmdCmp;
  logic [7:0] cmdMask;
  logic [7:0] cmdData;
  logic [63:0] cmdUid;
  logic actValid;
  logic [7:0] actCode;
  tcs_state_t tagState;
  logic [7:0] flagByte;
  logic [31:0] regRdata;
  int nFail = 0;
  int checks = 0;

  always #10 core_clk = ~core_clk;

  tcs_reader_model tcs_reader_model_i (.core_clk(core_clk), .cmdValid(cmdValid),
    .cmdCrcOk(cmdCrcOk), .cmdCode(cmdCode), .cmdCmp(cmdCmp), .cmdMask(cmdMask),
    .cmdData(cmdData), .cmdUid(cmdUid));

  tcs_state_ctrl tcs_state_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .cmdValid(cmdValid),
    .cmdCrcOk(cmdCrcOk), .cmdCode(cmdCode), .cmdCmp(cmdCmp), .cmdMask(cmdMask),
    .cmdData(cmdData), .cmdUid(cmdUid), .tagUid(OWN_UID), .memData(memData),
    .progDone(progDone), .progFail(progFail), .actValid(actValid), .actCode(actCode),
    .tagState(tagState), .flagByte(flagByte), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Result lands one edge after the command, so look just past it
  task automatic step(input logic [7:0] code, input int cmp, input logic [7:0] data,
      input logic hit, input logic [2:0] expState, input logic expAct, input logic crc = 1'b1);
    tcs_reader_model_i.send(code, 2'(cmp), data, hit ? OWN_UID : ~OWN_UID, crc);
    #1;
    check($sformatf("state after %h", code), 32'(tagState), 32'(expState));
    check($sformatf("act after %h", code), 32'(actValid), 32'(expAct));
    if (expAct) check($sformatf("code after %h", code), 32'(actCode), 32'(code));
  endtask : step

  task automatic prog(input logic ok);
    @(posedge core_clk);
    progDone <= ok;
    progFail <= ~ok;
    @(posedge core_clk);
    progDone <= 1'b0;
    progFail <= 1'b0;
    #1;
  endtask : prog

  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : regW

  task automatic regR(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), regRdata, exp);
    @(posedge core_clk);
    #1;
    check($sformatf("reg %h idle", a), regRdata, 32'h0);
  endtask : regR

  ////////////////////////////////////////////////////////////////
  task automatic tReset();
    check("reset state", 32'(tagState), 32'(RDY));
    check("reset flags", 32'(flagByte), 32'h0);
    regR(REG_STATUS, 32'h1);
    regR(REG_CTRL, 32'h1);
    $display("reset test done");
  endtask : tReset

  task automatic tIgnored();
    foreach (RDY_OFF[i]) step(RDY_OFF[i], 0, 8'h50, 1'b1, RDY, 1'b0);
    step(CMD_READ, 0, 8'h00, 1'b1, RDY, 1'b0, 1'b0);
    step(8'hff, 0, 8'h00, 1'b1, RDY, 1'b0);
    $display("ignored test done");
  endtask : tIgnored

  task automatic tPick();
    for (int c = 0; c < 4; c++) begin
      step(CMD_PICK_MEM, c, MISS_D[c], 1'b1, RDY, 1'b0);
      step(CMD_PICK_MEM, c, HIT_D[c], 1'b1, ARB, 1'b0);
      step(CMD_PICK_MEM, c, MISS_D[c], 1'b1, ARB, 1'b0);
      step(CMD_DROP_MEM, c, MISS_D[c], 1'b1, ARB, 1'b0);
      step(CMD_DROP_MEM, c, HIT_D[c], 1'b1, RDY, 1'b0);
    end
    step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
    $display("memory group test done");
  endtask : tPick

  task automatic tFlag();
    step(CMD_PICK_FLAG, CMP_GREATER, 8'h00, 1'b1, RDY, 1'b0);
    step(CMD_PICK_FLAG, CMP_NOT_EQUAL, 8'h00, 1'b1, RDY, 1'b0);
    step(CMD_PICK_FLAG, CMP_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_PICK_FLAG, CMP_NOT_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_DROP_FLAG, CMP_LESS, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_DROP_FLAG, CMP_NOT_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_DROP_FLAG, CMP_EQUAL, 8'h00, 1'b1, RDY, 1'b0);
    $display("flag group test done");
  endtask : tFlag

  task automatic tArb();
    step(CMD_PICK_FLAG, CMP_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
    foreach (RDY_OFF[i]) if (i > 2 && i != 6 && i != 7)
      step(RDY_OFF[i], 0, 8'h11, 1'b1, ARB, 1'b1);
    step(CMD_LOCK, 0, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_ARB_READ, 0, 8'h00, 1'b0, ARB, 1'b0);
    step(CMD_ARB_READ, 0, 8'h00, 1'b1, EXC, 1'b1);
    check("exchange flag", 32'(flagByte[0]), 32'h1);
    foreach (EXC_CMDS[i]) step(EXC_CMDS[i], 0, 8'h22, 1'b1, EXC, 1'b1);
    step(CMD_PICK_MEM, 0, 8'h50, 1'b1, EXC, 1'b0);
    step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
    check("flags after init", 32'(flagByte), 32'h0);
    $display("arbitration test done");
  endtask : tArb

  task automatic tAddr();
    foreach (ADDR_CMDS[i]) begin
      step(ADDR_CMDS[i], 0, 8'h00, 1'b0, RDY, 1'b0);
      step(ADDR_CMDS[i], 0, 8'h00, 1'b1, EXC, 1'b1);
      step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
      step(CMD_PICK_FLAG, CMP_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
      step(ADDR_CMDS[i], 0, 8'h00, 1'b0, ARB, 1'b0);
      step(ADDR_CMDS[i], 0, 8'h00, 1'b1, EXC, 1'b1);
      step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
    end
    $display("addressed test done");
  endtask : tAddr

  task automatic tWriteOk();
    step(CMD_VERIFIED_QUAD_READ, 0, 8'h00, 1'b1, RDY, 1'b0);
    step(CMD_PICK_FLAG, CMP_EQUAL, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_VERIFIED_QUAD_READ, 0, 8'h00, 1'b1, ARB, 1'b0);
    step(CMD_BCAST_WRITE, 0, 8'h3c, 1'b1, ARB, 1'b1);
    step(CMD_MULTI_DROP, 0, 8'h3c, 1'b1, ARB, 1'b0);
    step(CMD_BCAST_WRITE, 0, 8'h3c, 1'b1, ARB, 1'b1);
    prog(1'b1);
    check("write ok set", 32'(flagByte), 32'h2);
    step(CMD_MULTI_DROP, 0, 8'h3d, 1'b1, ARB, 1'b0);
    step(CMD_MULTI_DROP, 0, 8'h3c, 1'b1, RDY, 1'b0);
    step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
    check("write ok lapsed", 32'(flagByte), 32'h0);
    prog(1'b1);
    step(CMD_VERIFIED_QUAD_READ, 0, 8'h00, 1'b0, RDY, 1'b0);
    step(CMD_VERIFIED_QUAD_READ, 0, 8'h00, 1'b1, EXC, 1'b1);
    check("flags in exchange", 32'(flagByte), 32'h3);
    prog(1'b0);
    check("write ok cleared", 32'(flagByte), 32'h1);
    step(CMD_INIT, 0, 8'h00, 1'b0, RDY, 1'b1);
    $display("write ok test done");
  endtask : tWriteOk

  task automatic tRegs();
    regW(REG_CTRL, 32'h2);
    step(CMD_READ, 0, 8'h00, 1'b1, RDY, 1'b0);
    regR(REG_COUNT, 32'h0000_0100);
    regR(REG_CTRL, 32'h0);
    regW(REG_CTRL, 32'h1);
    regW(4'hc, 32'hffff_ffff);
    regR(4'hc, 32'h0);
    regR(REG_CTRL, 32'h1);
    regR(REG_STATUS, 32'h1);
    $display("register test done");
  endtask : tRegs

  ////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrapUp

  initial begin
    // Reset starts high so this drop is a real edge for the flops
    arst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    tReset();
    tIgnored();
    tPick();
    tFlag();
    tArb();
    tAddr();
    tWriteOk();
    tRegs();
    wrapUp();
  end

  // Hang guard: the whole run fits well inside this bound
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    wrapUp();
  end
endmodule : tb_tcs_state_ctrl
`default_nettype wire
